// File: rtl/pmicrg_regs.sv
// Purpose: switch event mask, status and control registers with interrupt gating
// Assumes: register port from the serial-bus slave, one-cycle strobes
// Notes:   event source flags are kept live here; masks gate only the output
//
// Notes on behaviour
// - six switch mask bits reset to zero; zero lets event pull irq low.
// - masks only gate the interrupt output; event recording continues unchanged.
// - status bit 7 reads one once freshness seal is broken, resets zero.
// - status bit 6 reads one when nonvolatile defaults were changed.
// - status bit 5 reads one while mains-detect pin is low.
// - status bit 4 reads one while push-button pin is low.
// - status bits 3-2 carry sequencer state code.
// - status bits 1-0 carry backup cell level code.
// - cell level is valid only after an acquisition completes.
// - writing one to start bit begins measurement; bit clears itself.
// - measurement done sets the acquisition-complete flag.
`timescale 1ns/1ps
`include "pmicrg_map.svh"
module pmicrg_regs (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       sw_fault_ev_clr,
  input  wire logic [2:0] sw_fault_ev,
  input  wire logic [2:0] sw_climit_ev,
  input  wire logic       seal_broken,
  input  wire logic       nvm_changed,
  input  wire logic       mains_detect_pin,
  input  wire logic       push_button_pin,
  input  wire logic [1:0] seq_state,
  input  wire logic [1:0] cell_cmp_level,
  input  wire logic       meas_done_clr,
  output logic [7:0]      reg_rdata,
  output logic [5:0]      switch_event_flags,
  output logic            cell_measure_done_flag,
  output logic            pfo_off_en,
  output logic            irq_out_n
);
  logic [7:0] switch_event_mask_q;
  logic [7:0] misc_control_q;
  logic       fresh_seal_broken_q;
  logic       nvm_modified_q;
  logic       mains_input_level_q;
  logic       button_input_level_q;
  logic [1:0] seq_state_q;
  logic [1:0] backup_cell_level;
  logic       meas_done;
  logic [7:0] status_val;
  logic [5:0] raw_ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  assign raw_ev = {sw_fault_ev, sw_climit_ev};

  // mask register, reserved bits held zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      switch_event_mask_q <= `PMICRG_MASK2_RESET;
    end else if (reg_wr && hit(reg_addr, `PMICRG_OFS_MASK2)) begin
      switch_event_mask_q <= reg_wdata & `PMICRG_MASK2_WMASK;
    end
  end

  // start bit self-clears the cycle after it is written
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      misc_control_q <= `PMICRG_CONTROL_RESET;
    end else begin
      misc_control_q[`PMICRG_BIT_MEAS_START] <= 1'b0;
      if (reg_wr && hit(reg_addr, `PMICRG_OFS_CONTROL)) begin
        misc_control_q <= reg_wdata & `PMICRG_CONTROL_WMASK;
      end
    end
  end

  pmicrg_cell_meas u_meas (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .start      (misc_control_q[`PMICRG_BIT_MEAS_START]),
    .cmp_level  (cell_cmp_level),
    .done_pulse (meas_done),
    .level_q    (backup_cell_level)
  );

  // source flags record regardless of mask; set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      switch_event_flags     <= 6'h00;
      cell_measure_done_flag <= 1'b0;
    end else begin
      switch_event_flags     <= (sw_fault_ev_clr ? 6'h00 : switch_event_flags) | raw_ev;
      cell_measure_done_flag <= (cell_measure_done_flag & ~meas_done_clr) | meas_done;
    end
  end

  // sampled status sources
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      fresh_seal_broken_q  <= 1'b0;
      nvm_modified_q       <= 1'b0;
      mains_input_level_q  <= 1'b0;
      button_input_level_q <= 1'b0;
      seq_state_q          <= pmicrg_pkg::PMICRG_SEQ_TRANSIT;
    end else begin
      fresh_seal_broken_q  <= seal_broken;
      nvm_modified_q       <= nvm_changed;
      mains_input_level_q  <= ~mains_detect_pin;
      button_input_level_q <= ~push_button_pin;
      seq_state_q          <= seq_state;
    end
  end

  always_comb begin
    status_val = {fresh_seal_broken_q, nvm_modified_q, mains_input_level_q,
                  button_input_level_q, seq_state_q, backup_cell_level};
  end

  // read mux; status is read-only, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, `PMICRG_OFS_MASK2)) begin
        reg_rdata <= switch_event_mask_q;
      end else if (hit(reg_addr, `PMICRG_OFS_STATUS)) begin
        reg_rdata <= status_val;
      end else if (hit(reg_addr, `PMICRG_OFS_CONTROL)) begin
        reg_rdata <= misc_control_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pfo_off_en <= 1'b0;
    end else begin
      pfo_off_en <= misc_control_q[`PMICRG_BIT_PFO_OFF];
    end
  end

  // unmasked flag pulls the output low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~|(switch_event_flags & ~switch_event_mask_q[5:0]);
    end
  end
endmodule : pmicrg_regs

// File: rtl/pmicrg_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the register bank
// Assumes: byte-wide registers at their subaddresses
// Notes:   included by the register bank and its cell measurement block
`ifndef PMICRG_MAP_SVH
`define PMICRG_MAP_SVH

`define PMICRG_OFS_MASK2       8'h04
`define PMICRG_OFS_STATUS      8'h05
`define PMICRG_OFS_CONTROL     8'h06

`define PMICRG_MASK2_RESET     8'h00
`define PMICRG_CONTROL_RESET   8'h00
`define PMICRG_MASK2_WMASK     8'h3F
`define PMICRG_CONTROL_WMASK   8'h03

`define PMICRG_BIT_SEAL        7
`define PMICRG_BIT_NVM         6
`define PMICRG_BIT_MAINS       5
`define PMICRG_BIT_BUTTON      4
`define PMICRG_BIT_MEAS_START  0
`define PMICRG_BIT_PFO_OFF     1

// comparator settling time of the cell measurement
`define PMICRG_SETTLE_NS       1000
`define PMICRG_CLK_NS          5
`define PMICRG_SETTLE_CYC      ((`PMICRG_SETTLE_NS + `PMICRG_CLK_NS - 1) / `PMICRG_CLK_NS)

`endif

// File: rtl/pmicrg_pkg.sv
// Purpose: types shared by the register bank
// Assumes: nothing
// Notes:   constants live in pmicrg_map.svh
package pmicrg_pkg;

  typedef enum logic [1:0] {
    PMICRG_SEQ_TRANSIT = 2'h0,
    PMICRG_SEQ_AWAIT   = 2'h1,
    PMICRG_SEQ_ACTIVE  = 2'h2,
    PMICRG_SEQ_SUSPEND = 2'h3
  } pmicrg_seq_t;

  typedef enum logic [1:0] {
    PMICRG_MS_IDLE   = 2'b00,
    PMICRG_MS_SETTLE = 2'b01,
    PMICRG_MS_DONE   = 2'b11
  } pmicrg_meas_t;

endpackage : pmicrg_pkg

// File: rtl/pmicrg_cell_meas.sv
// Purpose: backup cell level acquisition with settle timer and result register
// Assumes: comparator outputs synchronous to ref_clk
// Notes:   result reads 0 until the first acquisition completes
`timescale 1ns/1ps
`include "pmicrg_map.svh"
module pmicrg_cell_meas (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [1:0] cmp_level,
  output logic            done_pulse,
  output logic [1:0]      level_q
);
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(`PMICRG_SETTLE_CYC);

  pmicrg_pkg::pmicrg_meas_t state_q;
  logic [CNT_W-1:0]         cnt_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_q <= pmicrg_pkg::PMICRG_MS_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        pmicrg_pkg::PMICRG_MS_IDLE: begin
          if (start) begin
            state_q <= pmicrg_pkg::PMICRG_MS_SETTLE;
            cnt_q   <= '0;
          end
        end
        pmicrg_pkg::PMICRG_MS_SETTLE: begin
          if (cnt_q == SETTLE_CYC - CNT_W'(1)) begin
            state_q <= pmicrg_pkg::PMICRG_MS_DONE;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= pmicrg_pkg::PMICRG_MS_IDLE;
        end
      endcase
    end
  end

  // result captured only once comparators settled
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level_q    <= 2'h0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (state_q == pmicrg_pkg::PMICRG_MS_SETTLE && cnt_q == SETTLE_CYC - CNT_W'(1)) begin
        level_q    <= cmp_level;
        done_pulse <= 1'b1;
      end
    end
  end
endmodule : pmicrg_cell_meas

// File: tb/pmicrg_regs_monitor.sv
// Purpose: port checks of the register bank
// Assumes: status pins steady around reads
// Notes: bound to pmicrg_regs
`timescale 1ns/1ps
module pmicrg_regs_monitor (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [2:0] sw_fault_ev,
  input wire logic [2:0] sw_climit_ev,
  input wire logic       seal_broken,
  input wire logic       nvm_changed,
  input wire logic       mains_detect_pin,
  input wire logic       push_button_pin,
  input wire logic [1:0] seq_state,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] switch_event_flags,
  input wire logic       cell_measure_done_flag,
  input wire logic       irq_out_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire       srd = reg_rd && reg_addr == 8'h05;
  wire       cwr = reg_wr && reg_addr == 8'h06;
  wire [5:0] evs = {sw_fault_ev, sw_climit_ev};
  property p_rsv; reg_rd && reg_addr == 8'h04 |=> reg_rdata[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mask bits");
  property p_irq; !irq_out_n |-> $past(switch_event_flags) != 6'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  property p_rec; evs != 6'h00 |=> (switch_event_flags & $past(evs)) == $past(evs); endproperty
  a_rec: assert property (p_rec) else $error("event not recorded");
  property p_clr; cwr ##2 (reg_rd && reg_addr == 8'h06) |=> !reg_rdata[0]; endproperty
  a_clr: assert property (p_clr) else $error("start bit stuck");
  property p_done;
    cwr && reg_wdata[0] && !cell_measure_done_flag |=> ##[190:210] cell_measure_done_flag;
  endproperty
  a_done: assert property (p_done) else $error("no done flag");
  property p_nv;
    srd && $stable({seal_broken, nvm_changed}) |=>
      reg_rdata[7:6] == $past({seal_broken, nvm_changed});
  endproperty
  a_nv: assert property (p_nv) else $error("seal or nvm bit");
  property p_pin;
    srd && $stable({mains_detect_pin, push_button_pin}) |=>
      reg_rdata[5:4] == ~$past({mains_detect_pin, push_button_pin});
  endproperty
  a_pin: assert property (p_pin) else $error("pin level bits");
  property p_seq; srd && $stable(seq_state) |=> reg_rdata[3:2] == $past(seq_state); endproperty
  a_seq: assert property (p_seq) else $error("sequencer bits");
  c_irq: cover property (!irq_out_n);
  c_done: cover property ($rose(cell_measure_done_flag));
  c_srd: cover property (srd);
endmodule : pmicrg_regs_monitor
bind pmicrg_regs pmicrg_regs_monitor pmicrg_regs_monitor_i (.*);

// File: tb/pmicrg_host.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes set at falling edge
// Notes: idle address and data show the inverted last value
`timescale 1ns/1ps
module pmicrg_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    q = reg_rdata;
  endtask : acc
endmodule : pmicrg_host

// File: tb/test_pmicrg_regs.sv
// Purpose: register bank scenarios through the host port
// Assumes: cell settle near 200 cycles
// Notes: pins and events driven at falling edge
`timescale 1ns/1ps
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module test_pmicrg_regs;
  logic       ref_clk, rst_b, reg_wr, reg_rd, sw_fault_ev_clr, meas_done_clr;
  logic       seal_broken, nvm_changed, mains_detect_pin, push_button_pin;
  logic       cell_measure_done_flag, pfo_off_en, irq_out_n;
  logic [1:0] seq_state, cell_cmp_level;
  logic [2:0] sw_fault_ev, sw_climit_ev;
  logic [5:0] switch_event_flags;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  int         error_cnt = 0, n_checks = 0, cyc = 0;
  pmicrg_regs pmicrg_regs_i (.*);
  pmicrg_host pmicrg_host_i (.*);
  task automatic rd(input logic [7:0] a, e);
    pmicrg_host_i.acc(1'b0, a, 8'h00, q);
    `CK(q, e)
  endtask : rd
  // event and clear strobes, then wait for flags and irq
  task automatic ev(input logic [7:0] v);
    @(negedge ref_clk);
    {sw_fault_ev, sw_climit_ev, sw_fault_ev_clr, meas_done_clr} = v;
    @(negedge ref_clk);
    {sw_fault_ev, sw_climit_ev, sw_fault_ev_clr, meas_done_clr} = 8'h00;
    repeat (2) @(negedge ref_clk);
  endtask : ev
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end
  initial begin
    rst_b = 1'b0;
    cell_cmp_level = 2'h0;
    {seal_broken, nvm_changed, mains_detect_pin, push_button_pin, seq_state} = 6'h00;
    {sw_fault_ev, sw_climit_ev, sw_fault_ev_clr, meas_done_clr} = 8'h00;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    rd(8'h04, 8'h00);
    `CK(irq_out_n, 1'b1)
    pmicrg_host_i.acc(1'b1, 8'h04, 8'hFF, q);
    rd(8'h04, 8'h3F);
    pmicrg_host_i.acc(1'b1, 8'h06, 8'hFC, q);
    rd(8'h06, 8'h00);
    pmicrg_host_i.acc(1'b1, 8'h05, 8'hFF, q);
    for (int i = 0; i < 4; i++) begin
      {seal_broken, nvm_changed, mains_detect_pin, push_button_pin} = {i[0], i[1], i[0], !i[0]};
      seq_state = i[1:0];
      rd(8'h05, {i[0], i[1], !i[0], i[0], i[1:0], 2'h0});
    end
    ev(8'h20);
    `CK(switch_event_flags, 6'h08)
    `CK(irq_out_n, 1'b1)
    ev(8'h02);
    pmicrg_host_i.acc(1'b1, 8'h04, 8'h3E, q);
    ev(8'h04);
    `CK(switch_event_flags, 6'h01)
    `CK(irq_out_n, 1'b0)
    ev(8'h02);
    `CK(irq_out_n, 1'b1)
    for (int l = 0; l < 4; l++) begin
      cell_cmp_level = l[1:0];
      ev(8'h01);
      pmicrg_host_i.acc(1'b1, 8'h06, 8'h01, q);
      rd(8'h06, 8'h00);
      for (int k = 0; k < 300 && cell_measure_done_flag !== 1'b1; k++) @(negedge ref_clk);
      `CK(cell_measure_done_flag, 1'b1)
      rd(8'h05, {6'h37, l[1:0]});
    end
    // power-fail shutdown bit: read back and copied to its output
    pmicrg_host_i.acc(1'b1, 8'h06, 8'hFE, q);
    @(negedge ref_clk);
    `CK(pfo_off_en, 1'b1)
    rd(8'h06, 8'h02);
    wrap_up();
  end
endmodule : test_pmicrg_regs
